/* common/sf_defs.svh */
// Opcodes, field widths and timing counts for the serial flash host
`ifndef SF_DEFS_SVH
`define SF_DEFS_SVH

// Opcodes sent as the first byte of a frame
`define SF_OP_STATUS_STORE 8'h01
`define SF_OP_PAGE_WRITE   8'h02
`define SF_OP_PLAIN_READ   8'h03
`define SF_OP_WRITE_DISARM 8'h04
`define SF_OP_STATUS_FETCH 8'h05
`define SF_OP_WRITE_ARM    8'h06
`define SF_OP_QUICK_FETCH  8'h0B
`define SF_OP_WAKE         8'hAB
`define SF_OP_FULL_WIPE    8'hC7
`define SF_OP_SLEEP        8'hB9
`define SF_OP_BLOCK_CLEAR  8'hD8

// Frame layout
`define SF_ADDR_BYTES      2'd3
`define SF_QUICK_DUMMY     2'd1
`define SF_WAKE_DUMMY      2'd3

// Timing: system clock, serial clock and deselect gap, in ns
`define SF_CLK_NS          5
`define SF_SCLK_NS         40
`define SF_CS_GAP_NS       100
`define SF_HALF_CYC        (`SF_SCLK_NS / (2 * `SF_CLK_NS))
`define SF_GAP_CYC         ((`SF_CS_GAP_NS + `SF_CLK_NS - 1) / `SF_CLK_NS)

`endif

/* common/sf_pkg.sv */
// Types shared by the serial flash host
package sf_pkg;
  // Frame sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_SHIFT, ST_HOLD, ST_GAP} sf_state_e;
endpackage

/* core/sf_pair_buf.sv */
// Small valid/ready buffer of flip-flop entries
module sf_pair_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];  // Entry storage
  logic [AW-1:0]    wrPtr_reg;        // Next write slot
  logic [AW-1:0]    rdPtr_reg;        // Oldest entry
  logic [CW-1:0]    count_reg;        // Entries held
  logic             push;
  logic             pop;

  // Honest full and empty from the count
  assign inReady  = (count_reg != CW'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData  = mem_reg[rdPtr_reg];
  assign push     = ce && inValid && inReady;
  assign pop      = ce && outValid && outReady;

  // Pointer advance with wrap
  function automatic logic [AW-1:0] sfNextPtr(input logic [AW-1:0] p);
    sfNextPtr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // Entry write
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_reg[wrPtr_reg] <= inData;
    end
  end

  // Pointers and count
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr_reg <= sfNextPtr(wrPtr_reg);
      end
      if (pop)
      begin
        rdPtr_reg <= sfNextPtr(rdPtr_reg);
      end
      if (push && !pop)
      begin
        count_reg <= CW'(count_reg + 1'b1);
      end
      else if (pop && !push)
      begin
        count_reg <= CW'(count_reg - 1'b1);
      end
    end
  end
endmodule

/* core/sf_flash_host.sv */
// Host controller driving a serial NOR flash over its SPI pins
//
// Behaviour
// - Deselect only after whole bytes
// - Modifying commands preceded by write arm
// - Pause only while chip select low
// - Release pause before selecting again
// - Opcode first, everything MSB first
// - Read streams end after any bit; the host deselects only after whole read bytes
// - Arm, disarm, status opcodes and lengths
// - Plain and quick read byte layouts
// - Page write, block clear, full wipe layouts
// - Sleep and wake layouts
// - Data in on rise, out after fall
`include "sf_defs.svh"

module sf_flash_host (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        cmdValid,
  output logic             cmdReady,
  input  wire logic [7:0]  cmdOpcode,
  input  wire logic [19:0] cmdAddr,
  input  wire logic [8:0]  cmdTxLen,
  input  wire logic [15:0] cmdRxLen,
  input  wire logic        cmdAutoArm,
  input  wire logic [7:0]  txData,
  input  wire logic        txValid,
  output logic             txReady,
  output logic [7:0]       rxData,
  output logic             rxValid,
  input  wire logic        rxReady,
  input  wire logic        wpLevel,
  output logic             busy,
  output logic             sclk,
  output logic             csN,
  output logic             mosi,
  input  wire logic        miso,
  output logic             holdN,
  output logic             wpN
);
  sf_pkg::sf_state_e state_reg;  // Frame sequencer state
  logic [3:0]  divCnt_reg;       // Half period divider
  logic [4:0]  gapCnt_reg;       // Deselect gap counter
  logic        sclk_reg;         // Serial clock level
  logic        csN_reg;          // Chip select, low active
  logic        holdN_reg;        // Pause pin, low active
  logic        mosi_reg;         // Serial data out
  logic        wpN_reg;          // Protect pin
  logic [7:0]  outSh_reg;        // Outgoing bits
  logic [7:0]  inSh_reg;         // Incoming bits
  logic [3:0]  bitCnt_reg;       // Rising edges in byte
  logic        first_reg;        // Opcode still to send
  logic        curRx_reg;        // Byte in flight is read data
  logic        armPend_reg;      // Main frame follows arm frame
  logic [7:0]  op_reg;           // Saved user opcode
  logic [7:0]  curOp_reg;        // Opcode of this frame
  logic [23:0] addr_reg;         // Address bytes, top first
  logic [1:0]  addrLeft_reg;     // Address bytes left
  logic [1:0]  dumLeft_reg;      // Dummy bytes left
  logic [8:0]  txLen_reg;        // Saved write length
  logic [15:0] rxLen_reg;        // Saved read length
  logic [8:0]  txLeft_reg;       // Write bytes left
  logic [15:0] rxLeft_reg;       // Read bytes left
  logic [1:0]  misoSync_reg;     // Input synchroniser
  logic        halfTick;
  logic        riseEv;
  logic        fallEv;
  logic        byteEnd;
  logic        hdrDone;
  logic        needTx;
  logic        needRx;
  logic        frameDone;
  logic        rxSpace;
  logic        loadGo;
  logic [7:0]  nextByte;

  // Commands that change memory or status
  function automatic logic sfModifies(input logic [7:0] op);
    sfModifies = (op == `SF_OP_PAGE_WRITE) || (op == `SF_OP_BLOCK_CLEAR) ||
                 (op == `SF_OP_FULL_WIPE) || (op == `SF_OP_STATUS_STORE);
  endfunction

  // Commands that carry an address
  function automatic logic sfHasAddr(input logic [7:0] op);
    sfHasAddr = (op == `SF_OP_PLAIN_READ) || (op == `SF_OP_QUICK_FETCH) ||
                (op == `SF_OP_PAGE_WRITE) || (op == `SF_OP_BLOCK_CLEAR);
  endfunction

  // Dummy bytes; wake gets them only when signature is wanted
  function automatic logic [1:0] sfDummy(input logic [7:0] op, input logic rxWanted);
    if (op == `SF_OP_QUICK_FETCH)
    begin
      sfDummy = `SF_QUICK_DUMMY;
    end
    else if (op == `SF_OP_WAKE && rxWanted)
    begin
      sfDummy = `SF_WAKE_DUMMY;
    end
    else
    begin
      sfDummy = 2'd0;
    end
  endfunction

  // Event strobes of the bit engine
  always_comb
  begin
    halfTick  = (divCnt_reg == 4'(`SF_HALF_CYC - 1));
    riseEv    = ce && (state_reg == sf_pkg::ST_SHIFT) && halfTick && !sclk_reg;
    fallEv    = ce && (state_reg == sf_pkg::ST_SHIFT) && halfTick && sclk_reg;
    byteEnd   = fallEv && (bitCnt_reg == 4'd8);
    hdrDone   = !first_reg && (addrLeft_reg == 2'd0) && (dumLeft_reg == 2'd0);
    needTx    = hdrDone && (txLeft_reg != 9'd0);
    needRx    = hdrDone && (txLeft_reg == 9'd0) && (rxLeft_reg != 16'd0);
    frameDone = hdrDone && (txLeft_reg == 9'd0) && (rxLeft_reg == 16'd0);
    loadGo    = !(needTx && !txValid) && !(needRx && !rxSpace);
    if (first_reg)
    begin
      nextByte = curOp_reg;
    end
    else if (addrLeft_reg != 2'd0)
    begin
      nextByte = addr_reg[23:16];
    end
    else if (needTx)
    begin
      nextByte = txData;
    end
    else
    begin
      nextByte = 8'h00;
    end
  end

  assign cmdReady = (state_reg == sf_pkg::ST_IDLE);
  assign txReady  = (state_reg == sf_pkg::ST_LOAD) && needTx;
  assign busy     = (state_reg != sf_pkg::ST_IDLE);
  assign sclk     = sclk_reg;
  assign csN      = csN_reg;
  assign mosi     = mosi_reg;
  assign holdN    = holdN_reg;
  assign wpN      = wpN_reg;

  // Read data path; a stalled reader pauses the link, no word lost
  sf_pair_buf #(
    .WIDTH (8),
    .DEPTH (2)
  ) uRxBuf (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .ce       (ce),
    .inData   (inSh_reg),
    .inValid  (byteEnd && curRx_reg),
    .inReady  (rxSpace),
    .outData  (rxData),
    .outValid (rxValid),
    .outReady (rxReady)
  );

  // Input pin synchroniser
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      misoSync_reg <= 2'b00;
      wpN_reg      <= 1'b1;
    end
    else if (ce)
    begin
      misoSync_reg <= {misoSync_reg[0], miso};
      wpN_reg      <= wpLevel;
    end
  end

  // Serial clock divider and edges
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      divCnt_reg <= 4'd0;
      sclk_reg   <= 1'b0;
    end
    else if (ce)
    begin
      if (state_reg != sf_pkg::ST_SHIFT)
      begin
        divCnt_reg <= 4'd0;
        sclk_reg   <= 1'b0;
      end
      else if (halfTick)
      begin
        divCnt_reg <= 4'd0;
        sclk_reg   <= !sclk_reg;
      end
      else
      begin
        divCnt_reg <= 4'(divCnt_reg + 1'b1);
      end
    end
  end

  // Bit shifters: sample on rise, change after fall
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      outSh_reg  <= 8'h00;
      inSh_reg   <= 8'h00;
      bitCnt_reg <= 4'd0;
      mosi_reg   <= 1'b0;
    end
    else if (ce)
    begin
      if (state_reg == sf_pkg::ST_LOAD && !frameDone && loadGo)
      begin
        mosi_reg   <= nextByte[7];
        outSh_reg  <= {nextByte[6:0], 1'b0};
        bitCnt_reg <= 4'd0;
      end
      else if (riseEv)
      begin
        inSh_reg   <= {inSh_reg[6:0], misoSync_reg[1]};
        bitCnt_reg <= 4'(bitCnt_reg + 1'b1);
      end
      else if (fallEv && !byteEnd)
      begin
        mosi_reg  <= outSh_reg[7];
        outSh_reg <= {outSh_reg[6:0], 1'b0};
      end
    end
  end

  // Frame sequencer: select, byte counts, pause, deselect
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg    <= sf_pkg::ST_IDLE;
      csN_reg      <= 1'b1;
      holdN_reg    <= 1'b1;
      gapCnt_reg   <= 5'd0;
      first_reg    <= 1'b0;
      curRx_reg    <= 1'b0;
      armPend_reg  <= 1'b0;
      op_reg       <= 8'h00;
      curOp_reg    <= 8'h00;
      addr_reg     <= 24'h00_0000;
      addrLeft_reg <= 2'd0;
      dumLeft_reg  <= 2'd0;
      txLen_reg    <= 9'd0;
      rxLen_reg    <= 16'd0;
      txLeft_reg   <= 9'd0;
      rxLeft_reg   <= 16'd0;
    end
    else if (ce)
    begin
      unique case (state_reg)
        sf_pkg::ST_IDLE:
        begin
          if (cmdValid)
          begin
            op_reg    <= cmdOpcode;
            addr_reg  <= {4'h0, cmdAddr};
            txLen_reg <= cmdTxLen;
            rxLen_reg <= cmdRxLen;
            csN_reg   <= 1'b0;
            first_reg <= 1'b1;
            state_reg <= sf_pkg::ST_LOAD;
            if (cmdAutoArm && sfModifies(cmdOpcode))
            begin
              armPend_reg  <= 1'b1;
              curOp_reg    <= `SF_OP_WRITE_ARM;
              addrLeft_reg <= 2'd0;
              dumLeft_reg  <= 2'd0;
              txLeft_reg   <= 9'd0;
              rxLeft_reg   <= 16'd0;
            end
            else
            begin
              curOp_reg    <= cmdOpcode;
              addrLeft_reg <= sfHasAddr(cmdOpcode) ? `SF_ADDR_BYTES : 2'd0;
              dumLeft_reg  <= sfDummy(cmdOpcode, cmdRxLen != 16'd0);
              txLeft_reg   <= cmdTxLen;
              rxLeft_reg   <= cmdRxLen;
            end
          end
        end
        sf_pkg::ST_LOAD:
        begin
          if (frameDone)
          begin
            csN_reg    <= 1'b1;
            gapCnt_reg <= 5'd0;
            state_reg  <= sf_pkg::ST_GAP;
          end
          else if (loadGo)
          begin
            curRx_reg <= needRx;
            state_reg <= sf_pkg::ST_SHIFT;
            if (first_reg)
            begin
              first_reg <= 1'b0;
            end
            else if (addrLeft_reg != 2'd0)
            begin
              addrLeft_reg <= 2'(addrLeft_reg - 1'b1);
              addr_reg     <= {addr_reg[15:0], 8'h00};
            end
            else if (dumLeft_reg != 2'd0)
            begin
              dumLeft_reg <= 2'(dumLeft_reg - 1'b1);
            end
            else if (needTx)
            begin
              txLeft_reg <= 9'(txLeft_reg - 1'b1);
            end
            else
            begin
              rxLeft_reg <= 16'(rxLeft_reg - 1'b1);
            end
          end
          else if (needRx)
          begin
            holdN_reg <= 1'b0;
            state_reg <= sf_pkg::ST_HOLD;
          end
        end
        sf_pkg::ST_SHIFT:
        begin
          if (byteEnd)
          begin
            state_reg <= sf_pkg::ST_LOAD;
          end
        end
        sf_pkg::ST_HOLD:
        begin
          if (rxSpace)
          begin
            holdN_reg <= 1'b1;
            state_reg <= sf_pkg::ST_LOAD;
          end
        end
        sf_pkg::ST_GAP:
        begin
          gapCnt_reg <= 5'(gapCnt_reg + 1'b1);
          if (gapCnt_reg == 5'(`SF_GAP_CYC - 1))
          begin
            if (armPend_reg)
            begin
              armPend_reg  <= 1'b0;
              curOp_reg    <= op_reg;
              addrLeft_reg <= sfHasAddr(op_reg) ? `SF_ADDR_BYTES : 2'd0;
              dumLeft_reg  <= sfDummy(op_reg, rxLen_reg != 16'd0);
              txLeft_reg   <= txLen_reg;
              rxLeft_reg   <= rxLen_reg;
              first_reg    <= 1'b1;
              csN_reg      <= 1'b0;
              state_reg    <= sf_pkg::ST_LOAD;
            end
            else
            begin
              state_reg <= sf_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule

/* test/sf_flash_host_monitor.sv */
// Checker of serial pin timing at the flash host ports
module sf_flash_host_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic wpLevel,
  input wire logic busy,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic holdN,
  input wire logic wpN
);
  // Clock rises in the frame, modulo eight
  logic [2:0] bitCnt_reg;
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      bitCnt_reg <= 3'h0;
    else if (csN)
      bitCnt_reg <= 3'h0;
    else if ($rose(sclk))
      bitCnt_reg <= bitCnt_reg + 3'h1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_holdSel; !holdN |-> !csN; endproperty
  a_holdSel: assert property (p_holdSel) else $error("pause while deselected");
  property p_holdClk; !holdN |-> !sclk; endproperty
  a_holdClk: assert property (p_holdClk) else $error("pause with clock high");
  property p_relHold; $rose(csN) |-> holdN; endproperty
  a_relHold: assert property (p_relHold) else $error("deselect while paused");
  property p_whole; $rose(csN) |-> bitCnt_reg == 3'h0; endproperty
  a_whole: assert property (p_whole) else $error("frame not whole bytes");
  property p_idle; csN |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("clock high when idle");
  property p_mosi; sclk |-> $stable(mosi); endproperty
  a_mosi: assert property (p_mosi) else $error("data moved, clock high");
  property p_start; ce && cmdValid && cmdReady |=> busy && !csN; endproperty
  a_start: assert property (p_start) else $error("frame not opened");
  property p_holdEnd; $rose(holdN) |-> !sclk && !csN; endproperty
  a_holdEnd: assert property (p_holdEnd) else $error("pause ended with clock high");
  property p_wp; $stable(wpLevel) && $past(ce) |-> wpN == wpLevel; endproperty
  a_wp: assert property (p_wp) else $error("protect pin wrong");
  // Main scenarios
  c_hold: cover property (!holdN);
  c_end: cover property ($rose(csN));
  c_take: cover property (ce && cmdValid && cmdReady);
endmodule
bind sf_flash_host sf_flash_host_monitor mon_u (.ref_clk, .resetn, .ce, .cmdValid,
  .cmdReady, .wpLevel, .busy, .sclk, .csN, .mosi, .holdN, .wpN);

/* test/sf_flash_model.sv */
// Behavioural serial flash device driven through its pins
module sf_flash_model #(
  parameter logic [7:0] SIG = 8'h3C  // Signature byte, arbitrary value
) (
  input  wire logic sclk,
  input  wire logic csN,
  input  wire logic mosi,
  input  wire logic holdN,
  input  wire logic wpN,
  output logic      miso
);
  logic [7:0] stat_reg = 8'h00;  // Lock 7, guard 4:2, arm 1
  logic       sleep_reg = 1'b0;  // Sleep mode
  logic [7:0] mem [int];         // Programmed bytes, rest read ones
  logic [7:0] bq [$];            // Whole bytes of this frame
  logic [7:0] sh;                // Input shifter
  int         n;                 // Clock rises in frame
  initial miso = 1'b0;
  function automatic logic [7:0] rd(int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // Sector inside guard range
  function automatic logic guarded(logic [3:0] s, logic [2:0] r);
    return r > 3'h4 || (r != 3'h0 && s >= 4'(16 - (1 << (r - 1))));
  endfunction
  // Next output bit, inverse of last when none due
  function automatic logic obit();
    int         h;
    logic [7:0] b;
    h = bq[0] == 8'h05 ? 8 : (bq[0] == 8'h0B ? 40 : 32);
    if (n < h || (sleep_reg && bq[0] != 8'hAB))
      return ~miso;
    case (bq[0])
      8'h05: b = stat_reg;
      8'hAB: b = SIG;
      8'h03, 8'h0B: b = rd(int'({bq[1], bq[2], bq[3]}) + (n - h) / 8);
      default: return ~miso;
    endcase
    return b[7 - (n - h) % 8];
  endfunction
  // Command taken at deselect; internal cycles end at once, so no access meets one
  task automatic exec();
    int   a;
    logic ok;
    int   d [$];
    a = bq.size() > 3 ? int'({bq[1], bq[2], bq[3]}) : 0;
    ok = stat_reg[1] && !guarded(4'(a >> 16), stat_reg[4:2]);
    if (sleep_reg && bq[0] != 8'hAB)
      return;
    case (bq[0])
      8'h06: stat_reg[1] = 1'b1;
      8'hB9: sleep_reg = 1'b1;
      8'hAB: sleep_reg = 1'b0;
      8'h01: if (stat_reg[1] && bq.size() == 2 && !(stat_reg[7] && !wpN))
        stat_reg[7:2] = {bq[1][7], 2'b00, bq[1][4:2]};
      8'h02: if (ok)
        for (int i = 4; i < bq.size(); i++)
          mem[a + i - 4] = rd(a + i - 4) & bq[i];
      8'hD8: if (ok && bq.size() == 4)
      begin
        foreach (mem[k]) if (k >> 16 == a >> 16) d.push_back(k);
        foreach (d[j]) mem.delete(d[j]);
      end
      8'hC7: if (stat_reg[1] && stat_reg[4:2] == 3'h0)
        mem.delete();
      default: ;
    endcase
    if (bq[0] inside {8'h01, 8'h02, 8'h04, 8'hC7, 8'hD8})
      stat_reg[1] = 1'b0;
  endtask
  // Frame opens
  always @(negedge csN)
  begin
    n = 0;
    bq.delete();
  end
  // Input bits on rising clock, ignored while paused
  always @(posedge sclk)
    if (!csN && holdN)
    begin
      sh = {sh[6:0], mosi};
      n++;
      if (n % 8 == 0)
        bq.push_back(sh);
    end
  // Output after falling clock
  always @(negedge sclk)
    if (!csN && holdN && bq.size() > 0)
      miso <= obit();
  // Released line flips away from its last level
  always @(posedge csN or negedge holdN)
    miso <= ~miso;
  // Pending bit driven again once the pause ends
  always @(posedge holdN)
    if (!csN && bq.size() > 0)
      miso <= obit();
  // Only whole-byte, unpaused frames execute
  always @(posedge csN)
    if (n > 0 && n % 8 == 0 && holdN)
      exec();
endmodule

/* test/sf_flash_host_test.sv */
// Self-checking bench for the serial flash host and device model
module sf_flash_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, resetn, ce, cmdValid, cmdReady, cmdAutoArm;
  logic [7:0]  cmdOpcode, txData, rxData;
  logic [19:0] cmdAddr;
  logic [8:0]  cmdTxLen;
  logic [15:0] cmdRxLen;
  logic        txValid, txReady, rxValid, rxReady, wpLevel, busy;
  logic        sclk, csN, mosi, miso, holdN, wpN;
  logic [7:0]  txq [$];  // Write bytes to hand over
  logic [7:0]  rxq [$];  // Read bytes taken
  logic [7:0]  dat [4];  // Random page data
  int          checks;   // Comparisons made
  int          n_fail;   // Mismatches
  localparam logic [7:0] SIG = 8'h3C;  // Signature, arbitrary value
  sf_flash_host dut_u (.ref_clk, .resetn, .ce, .cmdValid, .cmdReady, .cmdOpcode, .cmdAddr,
    .cmdTxLen, .cmdRxLen, .cmdAutoArm, .txData, .txValid, .txReady, .rxData, .rxValid,
    .rxReady, .wpLevel, .busy, .sclk, .csN, .mosi, .miso, .holdN, .wpN);
  sf_flash_model #(.SIG(SIG)) dev_u (.sclk, .csN, .mosi, .holdN, .wpN, .miso);
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(string what, logic [7:0] got, logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Expected guard of a sector
  function automatic logic prot(logic [2:0] r, logic [3:0] s);
    return r == 3'h1 ? s == 4'hF : r == 3'h2 ? s > 4'hD : r == 3'h3 ? s > 4'hB :
           r == 3'h4 ? s[3] : r != 3'h0;
  endfunction
  // One command, streams served with long random read stalls and enable gaps
  task automatic run(logic [7:0] op, logic [19:0] a, int nrx, logic arm);
    int k;
    cmdOpcode <= op;
    cmdAddr <= a;
    cmdTxLen <= 9'(txq.size());
    cmdRxLen <= 16'(nrx);
    cmdAutoArm <= arm;
    cmdValid <= 1'b1;
    ce <= 1'b1;
    rxq.delete();
    k = 0;
    do
      @(posedge ref_clk);
    while (!cmdReady && ++k < 100);
    cmdValid <= 1'b0;
    for (k = k * 300; k < 30000; k++)
    begin
      @(posedge ref_clk);
      if (ce && txValid && txReady)
        void'(txq.pop_front());
      if (ce && rxValid && rxReady)
        rxq.push_back(rxData);
      txValid <= txq.size() > 0;
      txData <= txq.size() > 0 ? txq[0] : 8'h00;
      rxReady <= $urandom % 64 == 0;
      if (!busy && !rxValid)
        break;
      ce <= $urandom % 8 != 0;
    end
    if (k >= 29700)
    begin
      n_fail++;
      $display("MISMATCH command end expected done seen hung");
      end_of_test();
    end
  endtask
  task automatic st(logic [7:0] e);
    run(8'h05, 20'h0_0000, 2, 1'b0);
    chk("status", rxq[0], e);
    chk("status again", rxq[1], e);
  endtask
  task automatic setst(logic [7:0] v, logic [7:0] e);
    txq = {v};
    run(8'h01, 20'h0_0000, 0, 1'b1);
    st(e);
  endtask
  task automatic rd1(logic [19:0] a, logic [7:0] e);
    run(8'h03, a, 1, 1'b0);
    chk("plain read", rxq[0], e);
  endtask
  initial
  begin
    logic [3:0]  s;
    logic [19:0] a;
    resetn = 1'b0;
    ce = 1'b1;
    wpLevel = 1'b1;
    {cmdValid, cmdAutoArm, txValid, rxReady} = 4'h0;
    {cmdOpcode, txData, cmdAddr, cmdTxLen, cmdRxLen} = '0;
    checks = 0;
    n_fail = 0;
    void'($urandom(45107));
    repeat (12) @(posedge ref_clk);
    chk("idle pins", 8'({busy, sclk, csN, holdN, wpN}), 8'h07);
    resetn <= 1'b1;
    st(8'h00);
    run(8'h06, 20'h0_0000, 0, 1'b0);
    st(8'h02);
    run(8'h04, 20'h0_0000, 0, 1'b0);
    st(8'h00);
    txq = {8'h1C};
    run(8'h01, 20'h0_0000, 0, 1'b0);
    st(8'h00);
    wpLevel <= 1'b0;
    setst(8'h80, 8'h80);
    setst(8'h00, 8'h80);
    wpLevel <= 1'b1;
    setst(8'h00, 8'h00);
    run(8'hB9, 20'h0_0000, 0, 1'b0);
    run(8'h06, 20'h0_0000, 0, 1'b0);
    run(8'hAB, 20'h0_0000, 0, 1'b0);
    st(8'h00);
    run(8'hAB, 20'h0_0000, 2, 1'b0);
    chk("signature", rxq[1], SIG);
    // Every guard range against random sectors
    for (int r = 0; r < 8; r++)
    begin
      setst(8'(r << 2), 8'(r << 2));
      for (int j = 0; j < 3; j++)
      begin
        s = 4'($urandom);
        a = {s, 8'(r * 3 + j), 8'h00};
        foreach (dat[i]) dat[i] = 8'($urandom);
        txq = {dat[0], dat[1], dat[2], dat[3]};
        run(8'h02, a, 0, 1'b1);
        run(8'h0B, a, 4, 1'b0);
        foreach (dat[i]) chk("page data", rxq[i], prot(3'(r), s) ? 8'hFF : dat[i]);
      end
    end
    // Wipes, guarded and not
    a = 20'h5_FF00;
    setst(8'h00, 8'h00);
    txq = {8'hA5};
    run(8'h02, a, 0, 1'b1);
    setst(8'h04, 8'h04);
    run(8'hC7, 20'h0_0000, 0, 1'b1);
    rd1(a, 8'hA5);
    setst(8'h00, 8'h00);
    run(8'hD8, a, 0, 1'b1);
    rd1(a, 8'hFF);
    txq = {8'hA5};
    run(8'h02, a, 0, 1'b1);
    txq = {8'h5A};
    run(8'h02, a, 0, 1'b1);
    rd1(a, 8'h00);
    run(8'hC7, 20'h0_0000, 0, 1'b1);
    rd1(a, 8'hFF);
    end_of_test();
  end
endmodule
